/* File: include/two_wire_slave_map.vh */
// Register map, field positions, status codes and timing of the two-wire slave
`ifndef TWO_WIRE_SLAVE_MAP_VH
`define TWO_WIRE_SLAVE_MAP_VH
`define TW_OFS_OWN 8'h00
`define TW_OFS_CTRL 8'h04
`define TW_OFS_STAT 8'h08
`define TW_OFS_DATA 8'h0c
`define TW_OWN_RST 8'h00
`define TW_DATA_RST 8'hff
`define TW_B_DONE 7
`define TW_B_ACK 6
`define TW_B_STA 5
`define TW_B_STO 4
`define TW_B_WC 3
`define TW_B_EN 2
`define TW_B_IE 0
`define TW_ST_NONE 8'hf8
`define TW_ST_START 8'h08
`define TW_ST_SLAW 8'h60
`define TW_ST_GCA 8'h70
`define TW_ST_RXA 8'h80
`define TW_ST_RXN 8'h88
`define TW_ST_GRXA 8'h90
`define TW_ST_GRXN 8'h98
`define TW_ST_STOP 8'ha0
`define TW_ST_SLAR 8'ha8
`define TW_ST_ARBR 8'hb0
`define TW_ST_TXA 8'hb8
`define TW_ST_TXN 8'hc0
`define TW_ST_LASTA 8'hc8
`define TW_CLK_MHZ 100
`define TW_START_HOLD_NS 4000
`define TW_START_CYC ((`TW_START_HOLD_NS * `TW_CLK_MHZ + 999) / 1000)
`define TW_SCL_SETTLE 8
`endif

/* File: core/two_wire_slave_rx_tx.v */
// Two-wire slave receiver/transmitter with AXI4-Lite register access
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_slave_map.vh"
module two_wire_slave_rx_tx (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // AXI4-Lite write address
  input wire [7:0] awaddr,
  input wire awvalid,
  output wire awready,
  // AXI4-Lite write data
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  // AXI4-Lite write response
  output wire [1:0] bresp,
  output wire bvalid,
  input wire bready,
  // AXI4-Lite read
  input wire [7:0] araddr,
  input wire arvalid,
  output wire arready,
  output wire [31:0] rdata,
  output wire [1:0] rresp,
  output wire rvalid,
  input wire rready,
  // Two-wire bus pins, open drain
  input wire scl_i,
  output wire scl_o,
  output wire scl_oe,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe,
  // Power
  input wire deep_sleep,
  output wire wake_req
);
  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_ADDR = 8'h02;
  localparam [7:0] S_AACK = 8'h04;
  localparam [7:0] S_RX = 8'h08;
  localparam [7:0] S_RACK = 8'h10;
  localparam [7:0] S_TX = 8'h20;
  localparam [7:0] S_TACK = 8'h40;
  localparam [7:0] S_IGN = 8'h80;
  localparam [31:0] START_CYC_W = `TW_START_CYC;
  localparam [31:0] GEN_END_W = `TW_START_CYC + `TW_SCL_SETTLE;
  localparam [9:0] START_CYC = START_CYC_W[9:0];
  localparam [9:0] GEN_END = GEN_END_W[9:0];

  function [3:0] reg_sel;
    input [7:0] a;
    begin
      case (a)
        `TW_OFS_OWN: reg_sel = 4'h1;
        `TW_OFS_CTRL: reg_sel = 4'h2;
        `TW_OFS_STAT: reg_sel = 4'h4;
        `TW_OFS_DATA: reg_sel = 4'h8;
        default: reg_sel = 4'h0;
      endcase
    end
  endfunction

  reg awready_ff, aw_have_ff, wready_ff, w_have_ff, w_strb0_ff;
  reg bvalid_ff, arready_ff, rvalid_ff;
  reg [1:0] bresp_ff, rresp_ff;
  reg [7:0] aw_addr_ff;
  reg [31:0] w_data_ff, rdata_ff;
  reg [7:0] own_ff, data_ff, code_ff, sh_ff, tx_ff, st_ff;
  reg ack_en_ff, sta_ff, sto_ff, wc_ff, en_ff, ie_ff, done_ff;
  reg [2:0] scl_sy_ff, sda_sy_ff;
  reg scl_f_ff, sda_f_ff, busy_ff;
  reg [3:0] cnt_ff;
  reg [9:0] gen_cnt_ff;
  reg hold_ff, gc_ff, last_ff, mack_ff, rack_ff, post_ff, rx_load_ff;
  reg mst_ff, gen_scl_ff, sda_oe_ff, scl_oe_ff, wake_ff, low_ff;

  // Synchronised pins: a change counts once stages two and three agree
  wire scl_ok = scl_sy_ff[1] == scl_sy_ff[2];
  wire sda_ok = sda_sy_ff[1] == sda_sy_ff[2];
  wire scl_nx = scl_ok ? scl_sy_ff[2] : scl_f_ff;
  wire sda_nx = sda_ok ? sda_sy_ff[2] : sda_f_ff;
  wire scl_rise = scl_nx & ~scl_f_ff;
  wire scl_fall = ~scl_nx & scl_f_ff;
  wire start_ev = scl_f_ff & scl_nx & sda_f_ff & ~sda_nx;
  wire stop_ev = scl_f_ff & scl_nx & ~sda_f_ff & sda_nx;

  wire do_wr = aw_have_ff & w_have_ff & ~bvalid_ff;
  wire [3:0] wsel = reg_sel(aw_addr_ff);
  wire [3:0] rsel = reg_sel(araddr);
  wire wr_en = do_wr & w_strb0_ff;
  wire wr_own = wr_en & wsel[0];
  wire wr_ctrl = wr_en & wsel[1];
  wire wr_data = wr_en & wsel[3];
  wire clr_ev = wr_ctrl & w_data_ff[`TW_B_DONE] & done_ff;
  wire ack_now = wr_ctrl ? w_data_ff[`TW_B_ACK] : ack_en_ff;
  wire sto_now = wr_ctrl ? w_data_ff[`TW_B_STO] : sto_ff;

  wire own_hit = sh_ff[7:1] == own_ff[7:1];
  wire gc_hit = (sh_ff == 8'h00) & own_ff[0];
  wire addr_ok = ack_en_ff & (own_hit | gc_hit);
  wire [7:0] ctrl_rd = {done_ff, ack_en_ff, sta_ff, sto_ff, wc_ff, en_ff, 1'b0, ie_ff};
  wire [7:0] stat_rd = done_ff ? {code_ff[7:3], 3'b000} : `TW_ST_NONE;

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bresp = bresp_ff;
  assign bvalid = bvalid_ff;
  assign arready = arready_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign rvalid = rvalid_ff;
  assign scl_o = low_ff;
  assign sda_o = low_ff;
  assign scl_oe = scl_oe_ff;
  assign sda_oe = sda_oe_ff;
  assign wake_req = wake_ff;

  // Register bus slave: address and data may arrive in either order
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0000_0000;
      w_strb0_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'b00;
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= 2'b00;
    end
    else
    begin
      if (awvalid & awready_ff)
      begin
        aw_addr_ff <= awaddr;
        aw_have_ff <= 1'b1;
        awready_ff <= 1'b0;
      end
      if (wvalid & wready_ff)
      begin
        w_data_ff <= wdata;
        w_strb0_ff <= wstrb[0];
        w_have_ff <= 1'b1;
        wready_ff <= 1'b0;
      end
      if (do_wr)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff <= (wsel == 4'h0) ? 2'b10 : 2'b00;
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
      end
      if (bvalid_ff & bready)
      begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
      if (arvalid & arready_ff)
      begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rresp_ff <= (rsel == 4'h0) ? 2'b10 : 2'b00;
        case (rsel)
          4'h1: rdata_ff <= {24'h00_0000, own_ff};
          4'h2: rdata_ff <= {24'h00_0000, ctrl_rd};
          4'h4: rdata_ff <= {24'h00_0000, stat_rd};
          4'h8: rdata_ff <= {24'h00_0000, data_ff};
          default: rdata_ff <= 32'h0000_0000;
        endcase
      end
      if (rvalid_ff & rready)
      begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  // Software registers; hardware set of the done flag beats a clear
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      own_ff <= `TW_OWN_RST;
      data_ff <= `TW_DATA_RST;
      ack_en_ff <= 1'b0;
      sta_ff <= 1'b0;
      sto_ff <= 1'b0;
      wc_ff <= 1'b0;
      en_ff <= 1'b0;
      ie_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      if (wr_own)
        own_ff <= w_data_ff[7:0];
      if (wr_ctrl)
      begin
        ack_en_ff <= w_data_ff[`TW_B_ACK];
        sta_ff <= w_data_ff[`TW_B_STA];
        en_ff <= w_data_ff[`TW_B_EN];
        ie_ff <= w_data_ff[`TW_B_IE];
      end
      if (clr_ev & sto_now)
        sto_ff <= 1'b0;
      else if (wr_ctrl)
        sto_ff <= w_data_ff[`TW_B_STO];
      if (post_ff)
        done_ff <= 1'b1;
      else if (clr_ev)
        done_ff <= 1'b0;
      if (wr_data)
        wc_ff <= ~done_ff;
      // Bytes seen while asleep are not kept
      if (rx_load_ff & ~deep_sleep)
        data_ff <= sh_ff;
      else if (wr_data & done_ff)
        data_ff <= w_data_ff[7:0];
    end
  end

  // Bus protocol engine on sampled SCL and SDA
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      scl_sy_ff <= 3'b111;
      sda_sy_ff <= 3'b111;
      scl_f_ff <= 1'b1;
      sda_f_ff <= 1'b1;
      busy_ff <= 1'b0;
      st_ff <= S_IDLE;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      tx_ff <= 8'hff;
      code_ff <= `TW_ST_NONE;
      gen_cnt_ff <= 10'h000;
      hold_ff <= 1'b0;
      gc_ff <= 1'b0;
      last_ff <= 1'b0;
      mack_ff <= 1'b0;
      rack_ff <= 1'b0;
      post_ff <= 1'b0;
      rx_load_ff <= 1'b0;
      mst_ff <= 1'b0;
      gen_scl_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
      wake_ff <= 1'b0;
      low_ff <= 1'b0;
    end
    else
    begin
      scl_sy_ff <= {scl_sy_ff[1:0], scl_i};
      sda_sy_ff <= {sda_sy_ff[1:0], sda_i};
      scl_f_ff <= scl_nx;
      sda_f_ff <= sda_nx;
      low_ff <= 1'b0;
      post_ff <= 1'b0;
      rx_load_ff <= 1'b0;
      // Pending flag set counts too, else SCL is let go for one cycle
      scl_oe_ff <= ((done_ff | post_ff) & hold_ff) | gen_scl_ff;
      if (~deep_sleep)
        wake_ff <= 1'b0;
      if (start_ev)
        busy_ff <= 1'b1;
      else if (stop_ev)
      begin
        busy_ff <= 1'b0;
        mst_ff <= 1'b0;
      end
      if (~en_ff)
      begin
        st_ff <= S_IDLE;
        sda_oe_ff <= 1'b0;
        gen_cnt_ff <= 10'h000;
        gen_scl_ff <= 1'b0;
        hold_ff <= 1'b0;
      end
      else if ((start_ev | stop_ev) && gen_cnt_ff == 10'h000)
      begin
        if (st_ff == S_RX || st_ff == S_RACK)
        begin
          post_ff <= 1'b1;
          code_ff <= `TW_ST_STOP;
          hold_ff <= 1'b0;
        end
        st_ff <= start_ev ? S_ADDR : S_IDLE;
        cnt_ff <= 4'h0;
        sda_oe_ff <= 1'b0;
      end
      else if (clr_ev & sto_now)
      begin
        // Recovery: drop to unaddressed, release lines, no STOP sent
        st_ff <= S_IDLE;
        sda_oe_ff <= 1'b0;
        hold_ff <= 1'b0;
      end
      else
      begin
        case (st_ff)
          S_IDLE:
          begin
            if (gen_cnt_ff != 10'h000 || (sta_ff & ~busy_ff & ~done_ff))
            begin
              gen_cnt_ff <= gen_cnt_ff + 10'h001;
              sda_oe_ff <= 1'b1;
              if (gen_cnt_ff == START_CYC)
                gen_scl_ff <= 1'b1;
              // SDA let go only after SCL is low, so no STOP is made
              if (gen_cnt_ff == GEN_END)
              begin
                gen_cnt_ff <= 10'h000;
                gen_scl_ff <= 1'b0;
                sda_oe_ff <= 1'b0;
                mst_ff <= 1'b1;
                post_ff <= 1'b1;
                code_ff <= `TW_ST_START;
                hold_ff <= 1'b1;
              end
            end
          end
          S_ADDR:
          begin
            if (scl_rise)
            begin
              sh_ff <= {sh_ff[6:0], sda_nx};
              cnt_ff <= cnt_ff + 4'h1;
            end
            else if (scl_fall && cnt_ff == 4'h8)
            begin
              // In deep sleep a match also raises the wake request
              if (addr_ok)
              begin
                sda_oe_ff <= 1'b1;
                st_ff <= S_AACK;
                gc_ff <= gc_hit & ~own_hit;
                if (deep_sleep)
                  wake_ff <= 1'b1;
              end
              else
                st_ff <= S_IGN;
            end
          end
          S_AACK:
          begin
            if (scl_fall)
            begin
              sda_oe_ff <= 1'b0;
              cnt_ff <= 4'h0;
              post_ff <= 1'b1;
              hold_ff <= 1'b1;
              if (sh_ff[0])
              begin
                st_ff <= S_TX;
                code_ff <= mst_ff ? `TW_ST_ARBR : `TW_ST_SLAR;
              end
              else
              begin
                st_ff <= S_RX;
                code_ff <= gc_ff ? `TW_ST_GCA : `TW_ST_SLAW;
              end
            end
          end
          S_RX:
          begin
            if (scl_rise)
            begin
              sh_ff <= {sh_ff[6:0], sda_nx};
              cnt_ff <= cnt_ff + 4'h1;
            end
            else if (scl_fall && cnt_ff == 4'h8)
            begin
              rack_ff <= ack_en_ff;
              sda_oe_ff <= ack_en_ff;
              st_ff <= S_RACK;
            end
          end
          S_RACK:
          begin
            if (scl_fall)
            begin
              sda_oe_ff <= 1'b0;
              cnt_ff <= 4'h0;
              post_ff <= 1'b1;
              rx_load_ff <= 1'b1;
              hold_ff <= rack_ff;
              if (rack_ff)
              begin
                st_ff <= S_RX;
                code_ff <= gc_ff ? `TW_ST_GRXA : `TW_ST_RXA;
              end
              else
              begin
                st_ff <= S_IGN;
                code_ff <= gc_ff ? `TW_ST_GRXN : `TW_ST_RXN;
              end
            end
          end
          S_TX:
          begin
            if (clr_ev && cnt_ff == 4'h0)
            begin
              tx_ff <= data_ff;
              sda_oe_ff <= ~data_ff[7];
              last_ff <= ~ack_now;
            end
            if (scl_rise)
              cnt_ff <= cnt_ff + 4'h1;
            else if (scl_fall && cnt_ff == 4'h8)
            begin
              sda_oe_ff <= 1'b0;
              st_ff <= S_TACK;
            end
            else if (scl_fall && cnt_ff != 4'h0)
            begin
              tx_ff <= {tx_ff[6:0], 1'b1};
              sda_oe_ff <= ~tx_ff[6];
            end
          end
          S_TACK:
          begin
            if (scl_rise)
              mack_ff <= ~sda_nx;
            else if (scl_fall)
            begin
              cnt_ff <= 4'h0;
              post_ff <= 1'b1;
              if (mack_ff & ~last_ff)
              begin
                code_ff <= `TW_ST_TXA;
                hold_ff <= 1'b1;
                st_ff <= S_TX;
              end
              else
              begin
                code_ff <= mack_ff ? `TW_ST_LASTA : `TW_ST_TXN;
                hold_ff <= 1'b0;
                st_ff <= S_IGN;
              end
            end
          end
          S_IGN:
            sda_oe_ff <= 1'b0;
          default:
            st_ff <= S_IDLE;
        endcase
      end
    end
  end
endmodule // two_wire_slave_rx_tx
`default_nettype wire

/* File: verification/two_wire_slave_rx_tx_properties.sv */
// Register bus, pin level and wake checks of the two-wire slave
`timescale 1ns/1ps
`default_nettype none
module two_wire_slave_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register bus
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // Pins and power
  input wire logic scl_o,
  input wire logic sda_o,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic deep_sleep,
  input wire logic wake_req
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_r_lat;
    arvalid && arready |=> rvalid && !arready;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_unmapped;
    arvalid && arready && araddr > 8'h0c |=> rresp == 2'b10 && rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_stat_low;
    arvalid && arready && araddr == 8'h08 |=> rdata[2:0] == 3'b000 && rresp == 2'b00;
  endproperty
  a_stat_low: assert property (p_stat_low) else $error("status low bits set");
  property p_pins_low;
    scl_o == 1'b0 && sda_o == 1'b0;
  endproperty
  a_pins_low: assert property (p_pins_low) else $error("pin driven high");
  property p_wake_drop;
    !deep_sleep |=> !wake_req;
  endproperty
  a_wake_drop: assert property (p_wake_drop) else $error("wake request stuck");
  property p_wake_src;
    $rose(wake_req) |-> $past(deep_sleep);
  endproperty
  a_wake_src: assert property (p_wake_src) else $error("wake without sleep");
  property p_rst;
    disable iff (1'b0) rst |=> !scl_oe && !sda_oe && !bvalid && !rvalid;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule // two_wire_slave_checker
bind two_wire_slave_rx_tx two_wire_slave_checker chk_u (.clk_sys, .rst, .bresp, .bvalid,
  .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .scl_o, .sda_o,
  .scl_oe, .sda_oe, .deep_sleep, .wake_req);
`default_nettype wire

/* File: verification/two_wire_master_model.sv */
// Behavioural two-wire bus master, 160 ns bit time
`timescale 1ns/1ps
`default_nettype none
module two_wire_master_model (
  // Wire levels
  input wire logic scl,
  input wire logic sda,
  // Pull-downs
  output logic scl_oe,
  output logic sda_oe
);
  initial
  begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  // Also serves as repeated start
  task automatic start();
    sda_oe = 1'b0;
    #40 scl_oe = 1'b0;
    wait (scl);
    #80 sda_oe = 1'b1;
    #80 scl_oe = 1'b1;
  endtask
  task automatic stop();
    #40 sda_oe = 1'b1;
    #40 scl_oe = 1'b0;
    wait (scl);
    #80 sda_oe = 1'b0;
    #160;
  endtask
  // Waiting on SCL honours clock stretching
  task automatic bit_x(input logic b, output logic r);
    #40 sda_oe = ~b;
    #40 scl_oe = 1'b0;
    wait (scl);
    #40 r = sda;
    #40 scl_oe = 1'b1;
  endtask
  // Reads send 8'hff so SDA stays released
  task automatic xfer(input logic [7:0] d, input logic ab, output logic [7:0] r,
    output logic ar);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r[i]);
    bit_x(ab, ar);
    // Leaves the slave time to start stretching
    #240 sda_oe = 1'b0;
  endtask
endmodule // two_wire_master_model
`default_nettype wire

/* File: verification/two_wire_slave_rx_tx_bench.sv */
// Self-checking bench of the two-wire slave
`timescale 1ns/1ps
`default_nettype none
module two_wire_slave_rx_tx_bench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic deep_sleep = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, scl_o, sda_o, scl_oe, sda_oe, wake_req;
  wire [1:0] bresp;
  wire [1:0] rresp;
  wire [31:0] rdata;
  wire m_scl_oe, m_sda_oe;
  wire scl = ~(scl_oe | m_scl_oe);
  wire sda = ~(sda_oe | m_sda_oe);
  int mismatches = 0;
  int compares = 0;
  logic [7:0] own, b, qd;
  logic [1:0] rr, wresp;
  logic ak;
  logic [7:0] txq[$];
  logic [7:0] rv[5] = '{8'h00, 8'h00, 8'hf8, 8'hff, 8'h00};
  always #5 clk_sys = ~clk_sys;
  two_wire_slave_rx_tx dut_u (.clk_sys, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda), .sda_o, .sda_oe,
    .deep_sleep, .wake_req);
  two_wire_master_model m (.scl, .sda, .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Response ready raised late so the hold phase is exercised
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wvalid <= 1'b1;
    while (1'b1)
    begin
      @(posedge clk_sys);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid && bready)
        break;
      if (bvalid)
        bready <= 1'b1;
    end
    wresp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    while (1'b1)
    begin
      @(posedge clk_sys);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid && rready)
        break;
      if (rvalid)
        rready <= 1'b1;
    end
    b = rdata[7:0];
    rr = rresp;
    rready <= 1'b0;
  endtask
  task automatic stat(input logic [7:0] e);
    rd(8'h08);
    chk(b, e);
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #200000;
    mismatches++;
    test_done();
  end
  initial
  begin
    void'($urandom(67586));
    own = {7'($urandom_range(126, 1)), 1'b1};
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      rd(8'(4 * i));
      chk(b, rv[i]);
      chk({6'h0, rr}, (i == 4) ? 8'h02 : 8'h00);
    end
    wr(8'h00, own);
    wr(8'h04, 8'h44);
    m.start();
    m.xfer(8'h00, 1'b1, b, ak);
    chk({7'h0, ak}, 8'h00);
    stat(8'h70);
    wr(8'h04, 8'hc4);
    qd = 8'($urandom);
    m.xfer(qd, 1'b1, b, ak);
    chk({7'h0, ak}, 8'h00);
    stat(8'h90);
    rd(8'h0c);
    chk(b, qd);
    wr(8'h04, 8'h84);
    m.xfer(qd, 1'b1, b, ak);
    chk({7'h0, ak}, 8'h01);
    stat(8'h98);
    wr(8'h04, 8'h84);
    m.stop();
    m.start();
    m.xfer(own & 8'hfe, 1'b1, b, ak);
    chk({7'h0, ak}, 8'h01);
    m.stop();
    stat(8'hf8);
    wr(8'h04, 8'h44);
    m.start();
    m.xfer(own, 1'b1, b, ak);
    chk({7'h0, ak}, 8'h00);
    stat(8'ha8);
    // Two full bytes, then the last one after ack_enable drops
    for (int i = 0; i < 3; i++)
    begin
      txq.push_back(8'($urandom));
      wr(8'h0c, txq[0]);
      wr(8'h04, (i == 2) ? 8'h84 : 8'hc4);
      m.xfer(8'hff, 1'b0, b, ak);
      chk(b, txq.pop_front());
      stat((i == 2) ? 8'hc8 : 8'hb8);
    end
    wr(8'h04, 8'hc4);
    m.xfer(8'hff, 1'b0, b, ak);
    chk(b, 8'hff);
    stat(8'hf8);
    m.stop();
    m.start();
    m.xfer(own, 1'b1, b, ak);
    qd = 8'($urandom);
    wr(8'h0c, qd);
    wr(8'h04, 8'hc4);
    m.xfer(8'hff, 1'b1, b, ak);
    chk(b, qd);
    stat(8'hc0);
    wr(8'h04, 8'hc4);
    m.stop();
    m.start();
    m.xfer(own & 8'hfe, 1'b1, b, ak);
    stat(8'h60);
    wr(8'h04, 8'hc4);
    qd = 8'($urandom);
    m.xfer(qd, 1'b1, b, ak);
    stat(8'h80);
    chk({wrap_scl(), 7'h0}, 8'h80);
    wr(8'h04, 8'hc4);
    m.stop();
    stat(8'ha0);
    wr(8'h04, 8'hc4);
    wr(8'h00, own & 8'hfe);
    m.start();
    m.xfer(8'h00, 1'b1, b, ak);
    chk({7'h0, ak}, 8'h01);
    m.stop();
    @(posedge clk_sys);
    deep_sleep <= 1'b1;
    m.start();
    m.xfer(own & 8'hfe, 1'b1, b, ak);
    chk({7'h0, ak}, 8'h00);
    chk({6'h0, wake_req, scl_oe}, 8'h03);
    @(posedge clk_sys);
    deep_sleep <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk({6'h0, wake_req, scl_oe}, 8'h01);
    wr(8'h04, 8'hc4);
    m.stop();
    stat(8'ha0);
    // Own START on the free bus, then a read address makes the lost-arbitration entry
    wr(8'h04, 8'he4);
    repeat (450) @(posedge clk_sys);
    stat(8'h08);
    chk({7'h0, scl_oe}, 8'h01);
    wr(8'h04, 8'hc4);
    m.start();
    m.xfer(own, 1'b1, b, ak);
    chk({7'h0, ak}, 8'h00);
    stat(8'hb0);
    wr(8'h04, 8'hd4);
    m.stop();
    stat(8'hf8);
    wr(8'h0c, 8'h5a);
    chk({6'h0, wresp}, 8'h00);
    rd(8'h04);
    chk(b, 8'h4c);
    rd(8'h0c);
    chk(b, qd);
    wr(8'h10, 8'h00);
    chk({6'h0, wresp}, 8'h02);
    test_done();
  end
  function automatic logic wrap_scl();
    return scl_oe;
  endfunction
endmodule // two_wire_slave_rx_tx_bench
`default_nettype wire
